// ===== hw/ots_core.sv
/*
 Overtravel stop selection, emergency torque clamp and warning output.
 Assumes synchronous inputs; the motion loops outside act on drive outputs.
*/
`timescale 1ns/1ps
`include "ots_defines.svh"
// What this block does
// - low digit selects braking or coasting stop
// - second digit picks decel then clamp/coast
// - torque mode never decelerates, ends coasting
// - decel uses emergency torque setting, immediate
// - applied torque clamped to motor maximum
// - zero clamp holds position reference zero
// - warning enable digit, immediate effect
// - flag warning on trip with power on
// - with reference, warn matching direction only
// - no warning for opposite direction limit
// - no reference: warn either limit
// - no warning raised while motor power off
// - no warning for limit present at power-on
// - warning held while tripped, clears one second after release
// - warning never alters stop processing
// - inactive limit input means overtravel
// - opposite direction motion still allowed
module ots_core
    import ots_pkg::*;
#(
    parameter int HOLD_CYCLES = `OTS_HOLD_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       nrst,
    input  wire logic       forward_limit_input,
    input  wire logic       reverse_limit_input,
    input  wire logic [1:0] stop_method_low,
    input  wire logic [1:0] stop_method_mode,
    input  wire logic [9:0] emergency_torque_setting,
    input  wire logic [9:0] motor_max_torque,
    input  wire logic       travel_warning_enable,
    input  wire logic       torque_mode,
    input  wire logic       power_on,
    input  wire logic       motor_stopped,
    input  wire ots_dir_s   ref_dir,
    output ots_drive_s      drive,
    output logic            pos_ref_zero,
    output ots_dir_s        motion_allow,
    output logic            overtravel,
    output logic            travel_warning,
    output logic [7:0]      travel_warning_code
);
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("hold count must be positive");
    end

    ots_state_e  st_r, st_nxt;
    logic [1:0]  low_r, low_nxt;
    logic [1:0]  mode_r, mode_nxt;
    logic        cfg_done_r, cfg_done_nxt;
    ots_drive_s  drive_r, drive_nxt;
    ots_dir_s    ot;
    ots_dir_s    ot_move;
    logic [9:0]  tq_set;
    logic        warn;

    always_comb begin
        ot.fwd = !forward_limit_input;
        ot.rev = !reverse_limit_input;
        // a limit trips the stop only when the reference pushes into it, or with no reference
        ot_move.fwd = ot.fwd && !ref_dir.rev;
        ot_move.rev = ot.rev && !ref_dir.fwd;
        tq_set = (emergency_torque_setting > 10'(`OTS_TORQUE_MAX_SET)) ?
                 10'(`OTS_TORQUE_MAX_SET) : emergency_torque_setting;
        // config sampled once after reset, since the method takes effect only on restart
        cfg_done_nxt = 1'b1;
        low_nxt  = cfg_done_r ? low_r  : stop_method_low;
        mode_nxt = cfg_done_r ? mode_r : stop_method_mode;
    end

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            OTS_RUN: begin
                if (power_on && (ot_move.fwd || ot_move.rev)) begin
                    if (!torque_mode &&
                        (mode_r == `OTS_AFTER_DECEL_ZC || mode_r == `OTS_AFTER_DECEL_CST)) begin
                        st_nxt = OTS_DECEL;
                    end else if (low_r == `OTS_STOP_COAST) begin
                        st_nxt = OTS_COAST;
                    end else begin
                        st_nxt = OTS_DBRAKE;
                    end
                end
            end
            OTS_DBRAKE, OTS_COAST: begin
                if (motor_stopped) st_nxt = OTS_FREE;
            end
            OTS_DECEL: begin
                if (motor_stopped) begin
                    st_nxt = (mode_r == `OTS_AFTER_DECEL_ZC) ? OTS_ZCLAMP : OTS_FREE;
                end
            end
            OTS_ZCLAMP, OTS_FREE: begin
                ;
            end
            default: st_nxt = OTS_RUN;
        endcase
        if (!power_on || !(ot_move.fwd || ot_move.rev)) st_nxt = OTS_RUN;
    end

    always_comb begin
        drive_nxt = '0;
        case (st_nxt)
            OTS_DBRAKE: drive_nxt.dynamic_braking = 1'b1;
            OTS_COAST, OTS_FREE: drive_nxt.coast = 1'b1;
            OTS_DECEL: begin
                drive_nxt.decel        = 1'b1;
                drive_nxt.torque_limit = (tq_set > motor_max_torque) ?
                                         motor_max_torque : tq_set;
            end
            OTS_ZCLAMP: drive_nxt.zero_clamp = 1'b1;
            default: drive_nxt = '0;
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_r       <= OTS_RUN;
            low_r      <= `OTS_STOP_DB0;
            mode_r     <= 2'h0;
            cfg_done_r <= 1'b0;
            drive_r    <= '0;
        end else begin
            st_r       <= st_nxt;
            low_r      <= low_nxt;
            mode_r     <= mode_nxt;
            cfg_done_r <= cfg_done_nxt;
            drive_r    <= drive_nxt;
        end
    end

    // warning path is separate and feeds nothing back into the stop logic
    ots_warn_hold #(
        .HOLD_CYCLES (HOLD_CYCLES)
    ) i_ots_warn_hold (
        .clk      (clk),
        .nrst     (nrst),
        .enable   (travel_warning_enable),
        .power_on (power_on),
        .ot       (ot),
        .ref_dir  (ref_dir),
        .warn     (warn)
    );

    assign drive               = drive_r;
    assign pos_ref_zero        = drive_r.zero_clamp;
    assign motion_allow.fwd    = !ot.fwd;
    assign motion_allow.rev    = !ot.rev;
    assign overtravel          = ot.fwd || ot.rev;
    assign travel_warning      = warn;
    assign travel_warning_code = warn ? `OTS_WARN_CODE : 8'h00;

    property p_torque_no_decel;
        @(posedge clk) disable iff (!nrst) (torque_mode && st_r == OTS_RUN) |=> st_r != OTS_DECEL;
    endproperty
    a_torque_no_decel: assert property (p_torque_no_decel) else $error("decel in torque mode");

    property p_torque_clamp;
        @(posedge clk) disable iff (!nrst) drive_r.decel |-> (drive_r.torque_limit <= motor_max_torque);
    endproperty
    a_torque_clamp: assert property (p_torque_clamp) else $error("torque above motor maximum");

    property p_torque_cap;
        @(posedge clk) disable iff (!nrst) drive_r.decel |-> (drive_r.torque_limit <= 10'h320);
    endproperty
    a_torque_cap: assert property (p_torque_cap) else $error("torque above setting range");

    property p_zc_after_decel;
        @(posedge clk) disable iff (!nrst) (st_r == OTS_ZCLAMP) |-> $past(st_r) inside {OTS_DECEL, OTS_ZCLAMP};
    endproperty
    a_zc_after_decel: assert property (p_zc_after_decel) else $error("zero clamp without decel");

    property p_coast_stop;
        @(posedge clk) disable iff (!nrst)
            (st_r == OTS_RUN && power_on && ot_move.fwd && !torque_mode && mode_r == 2'h0 && low_r == 2'h2)
            |=> drive_r.coast;
    endproperty
    a_coast_stop: assert property (p_coast_stop) else $error("coast stop not chosen");

    property p_zc_ref;
        @(posedge clk) disable iff (!nrst) drive_r.zero_clamp |-> pos_ref_zero && !drive_r.coast;
    endproperty
    a_zc_ref: assert property (p_zc_ref) else $error("zero clamp without zero reference");

    // a pushing forward limit with power on must always leave run
    property p_limit_stops;
        @(posedge clk) disable iff (!nrst)
            (st_r == OTS_RUN && power_on && !forward_limit_input && !ref_dir.rev)
            |=> (drive_r.dynamic_braking || drive_r.coast || drive_r.decel);
    endproperty
    a_limit_stops: assert property (p_limit_stops) else $error("limit did not start a stop");

    // reverse reference away from a tripped forward limit must release every stop output
    property p_opposite_release;
        @(posedge clk) disable iff (!nrst)
            (!forward_limit_input && reverse_limit_input && ref_dir.rev)
            |=> (drive_r == '0);
    endproperty
    a_opposite_release: assert property (p_opposite_release) else $error("stop held against free side");

    property p_torque_stop;
        @(posedge clk) disable iff (!nrst)
            (torque_mode && st_r == OTS_RUN && power_on && (ot_move.fwd || ot_move.rev))
            |=> (drive_r.dynamic_braking || drive_r.coast);
    endproperty
    a_torque_stop: assert property (p_torque_stop) else $error("torque mode stop not brake or coast");

    property p_torque_after_stop;
        @(posedge clk) disable iff (!nrst)
            (torque_mode && st_r inside {OTS_DBRAKE, OTS_COAST} && motor_stopped && power_on &&
             (ot_move.fwd || ot_move.rev))
            |=> (drive_r.coast && !drive_r.zero_clamp);
    endproperty
    a_torque_after_stop: assert property (p_torque_after_stop) else $error("torque mode stop not coasting");

    property p_decel_to_clamp;
        @(posedge clk) disable iff (!nrst)
            (st_r == OTS_DECEL && mode_r == `OTS_AFTER_DECEL_ZC && motor_stopped && power_on &&
             (ot_move.fwd || ot_move.rev))
            |=> (drive_r.zero_clamp && pos_ref_zero);
    endproperty
    a_decel_to_clamp: assert property (p_decel_to_clamp) else $error("no zero clamp after decel");

    // digits frozen after the first edge, so a change waits for restart
    property p_cfg_frozen;
        @(posedge clk) disable iff (!nrst)
            cfg_done_r |=> ($stable(low_r) && $stable(mode_r));
    endproperty
    a_cfg_frozen: assert property (p_cfg_frozen) else $error("stop digits changed without restart");
endmodule

// ===== hw/ots_defines.svh
/*
 Timing counts, codes and defaults for the overtravel stop and warning block.
 Assumes a 100 MHz clock; included by bare name.
*/
`ifndef OTS_DEFINES_SVH
`define OTS_DEFINES_SVH
`define OTS_CLK_MHZ          100
`define OTS_HOLD_MS          1000
`define OTS_HOLD_CYCLES      (`OTS_HOLD_MS * 1000 * `OTS_CLK_MHZ)
`define OTS_TORQUE_MAX_SET   800
`define OTS_TORQUE_RESET     10'h320
`define OTS_STOP_DB0         2'h0
`define OTS_STOP_DB1         2'h1
`define OTS_STOP_COAST       2'h2
`define OTS_AFTER_DECEL_ZC   2'h1
`define OTS_AFTER_DECEL_CST  2'h2
`define OTS_WARN_CODE        8'hA0
`endif

// ===== hw/ots_pkg.sv
/*
 Types for the overtravel stop and warning block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ots_pkg;
    typedef enum logic [2:0] {
        OTS_RUN     = 3'h0,
        OTS_DBRAKE  = 3'h1,
        OTS_COAST   = 3'h2,
        OTS_DECEL   = 3'h3,
        OTS_ZCLAMP  = 3'h4,
        OTS_FREE    = 3'h5
    } ots_state_e;

    typedef struct packed {
        logic       fwd;
        logic       rev;
    } ots_dir_s;

    typedef struct packed {
        logic       dynamic_braking;
        logic       coast;
        logic       decel;
        logic       zero_clamp;
        logic [9:0] torque_limit;
    } ots_drive_s;
endpackage

// ===== hw/ots_warn_hold.sv
/*
 Overtravel warning detector with one second hold.
 Assumes synchronous inputs and the 100 MHz clock of the parent.
*/
`timescale 1ns/1ps
`include "ots_defines.svh"
module ots_warn_hold
    import ots_pkg::*;
#(
    parameter int HOLD_CYCLES = `OTS_HOLD_CYCLES
) (
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     enable,
    input  wire logic     power_on,
    input  wire ots_dir_s ot,
    input  wire ots_dir_s ref_dir,
    output logic          warn
);
    if (HOLD_CYCLES < 1) begin : g_bad_hold
        $error("hold count must be positive");
    end

    logic [31:0] cnt_r, cnt_nxt;
    logic        warn_r, warn_nxt;
    logic        pwr_r, pwr_nxt;
    ots_dir_s    ot_r, ot_nxt;
    logic        qual;
    logic        none_ref;

    always_comb begin
        none_ref = !ref_dir.fwd && !ref_dir.rev;
        // only rising limits count, so limits already active at power-up are skipped
        qual = enable && power_on && pwr_r &&
               ((ot.fwd && !ot_r.fwd && (ref_dir.fwd || none_ref)) ||
                (ot.rev && !ot_r.rev && (ref_dir.rev || none_ref)));
        ot_nxt   = ot;
        pwr_nxt  = power_on;
        warn_nxt = warn_r;
        cnt_nxt  = cnt_r;
        if (!enable) begin
            warn_nxt = 1'b0;
            cnt_nxt  = '0;
        end else if (qual) begin
            warn_nxt = 1'b1;
            cnt_nxt  = 32'(HOLD_CYCLES);
        end else if (warn_r && (ot.fwd || ot.rev)) begin
            cnt_nxt  = 32'(HOLD_CYCLES);
        end else if (warn_r) begin
            if (cnt_r <= 32'h1) begin
                warn_nxt = 1'b0;
                cnt_nxt  = '0;
            end else begin
                cnt_nxt  = cnt_r - 32'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r  <= '0;
            warn_r <= 1'b0;
            pwr_r  <= 1'b0;
            ot_r   <= '0;
        end else begin
            cnt_r  <= cnt_nxt;
            warn_r <= warn_nxt;
            pwr_r  <= pwr_nxt;
            ot_r   <= ot_nxt;
        end
    end

    assign warn = warn_r;

    property p_no_warn_power_off;
        @(posedge clk) disable iff (!nrst) (!power_on && !warn_r) |=> !warn_r;
    endproperty
    a_no_warn_power_off: assert property (p_no_warn_power_off) else $error("warning rose with power off");

    property p_disabled_clear;
        @(posedge clk) disable iff (!nrst) !enable |=> !warn_r;
    endproperty
    a_disabled_clear: assert property (p_disabled_clear) else $error("warning while disabled");

    property p_opposite_quiet;
        @(posedge clk) disable iff (!nrst)
            (!warn_r && ref_dir.fwd && !ref_dir.rev && !(ot.fwd && !ot_r.fwd)) |=> !warn_r;
    endproperty
    a_opposite_quiet: assert property (p_opposite_quiet) else $error("warning for opposite limit");
endmodule

// ===== test/ots_host_model.sv
/*
 Host controller model: motor power request and reference direction.
 Assumes the bench clock and reset; the bench says what the host wants.
*/
`timescale 1ns/1ps
module ots_host_model
    import ots_pkg::*;
#(
    parameter int SETTLE_CYCLES = 8
) (
    input  wire logic     clk,
    input  wire logic     nrst,
    input  wire logic     servo_req,
    input  wire ots_dir_s want_dir,
    output logic          power_on,
    output ots_dir_s      ref_dir
);
    int wait_r;

    // brake release plus margin, shortened for simulation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_r <= 0;
        end else if (!servo_req) begin
            wait_r <= 0;
        end else if (wait_r < SETTLE_CYCLES) begin
            wait_r <= wait_r + 1;
        end
    end

    assign power_on = servo_req;
    // no reference until the settle time has run out
    assign ref_dir  = (wait_r >= SETTLE_CYCLES) ? want_dir : 2'h0;
endmodule

// ===== test/ots_core_bench.sv
/*
 Bench for the overtravel stop and warning block.
 Assumes the package and header on the include path; hold shortened to 20.
*/
`timescale 1ns/1ps
module ots_core_bench;
    import ots_pkg::*;
    logic       clk;
    logic       nrst;
    logic       forward_limit_input;
    logic       reverse_limit_input;
    logic [1:0] stop_method_low;
    logic [1:0] stop_method_mode;
    logic [9:0] emergency_torque_setting;
    logic [9:0] motor_max_torque;
    logic       travel_warning_enable;
    logic       torque_mode;
    logic       power_on;
    logic       motor_stopped;
    logic       servo_req;
    ots_dir_s   want_dir;
    ots_dir_s   ref_dir;
    ots_drive_s drive;
    logic       pos_ref_zero;
    ots_dir_s   motion_allow;
    logic       overtravel;
    logic       travel_warning;
    logic [7:0] travel_warning_code;
    int         n_fail;
    int         check_count;
    int         cycles;
    // low, mode, torque mode, first {brake,coast,decel,clamp}, after {coast,clamp,zero ref}
    logic [11:0] cfg [7] = '{{2'h0, 2'h0, 1'h0, 4'h8, 3'h4}, {2'h1, 2'h0, 1'h0, 4'h8, 3'h4},
                            {2'h2, 2'h0, 1'h0, 4'h4, 3'h4}, {2'h0, 2'h1, 1'h0, 4'h2, 3'h3},
                            {2'h0, 2'h2, 1'h0, 4'h2, 3'h4}, {2'h1, 2'h1, 1'h1, 4'h8, 3'h4},
                            {2'h2, 2'h2, 1'h1, 4'h4, 3'h4}};

    ots_core #(.HOLD_CYCLES(20)) i_ots_core (.clk, .nrst, .forward_limit_input, .reverse_limit_input,
        .stop_method_low, .stop_method_mode, .emergency_torque_setting, .motor_max_torque,
        .travel_warning_enable, .torque_mode, .power_on, .motor_stopped, .ref_dir, .drive,
        .pos_ref_zero, .motion_allow, .overtravel, .travel_warning, .travel_warning_code);
    ots_host_model i_ots_host_model (.clk, .nrst, .servo_req, .want_dir, .power_on, .ref_dir);

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask

    // stop digits are only taken at the first edge after reset
    task automatic restart(input logic [1:0] low, input logic [1:0] mode, input logic tmode);
        nrst = 1'h0;
        servo_req = 1'h0;
        forward_limit_input = 1'h1;
        reverse_limit_input = 1'h1;
        motor_stopped = 1'h0;
        want_dir = 2'h0;
        stop_method_low = low;
        stop_method_mode = mode;
        torque_mode = tmode;
        step(6);
        nrst = 1'h1;
        step(2);
        servo_req = 1'h1;
        step(12);
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            summarize();
        end
    end

    initial begin
        n_fail = 0;
        check_count = 0;
        cycles = 0;
        emergency_torque_setting = 10'h384;
        motor_max_torque = 10'h12C;
        travel_warning_enable = 1'h1;
        restart(2'h0, 2'h0, 1'h0);
        check(drive, 16'h0);
        for (int i = 0; i < 7; i++) begin
            restart(cfg[i][11:10], cfg[i][9:8], cfg[i][7]);
            forward_limit_input = 1'h0;
            step(3);
            check({drive.dynamic_braking, drive.coast, drive.decel, drive.zero_clamp}, cfg[i][6:3]);
            check(drive.torque_limit, (cfg[i][6:3] == 4'h2) ? 16'h12C : 16'h0);
            check({motion_allow, overtravel}, 3'h3);
            check({travel_warning, travel_warning_code}, 9'h1A0);
            motor_stopped = 1'h1;
            step(3);
            check({drive.coast, drive.zero_clamp, pos_ref_zero}, cfg[i][2:0]);
            forward_limit_input = 1'h1;
            motor_stopped = 1'h0;
            step(3);
            check(drive, 16'h0);
        end
        $display("test stop methods done");
        restart(2'h0, 2'h1, 1'h0);
        emergency_torque_setting = 10'h3E8;
        motor_max_torque = 10'h3FF;
        reverse_limit_input = 1'h0;
        step(3);
        check(drive.torque_limit, 10'h320);
        emergency_torque_setting = 10'h0C8;
        step(2);
        check(drive.torque_limit, 10'h0C8);
        reverse_limit_input = 1'h1;
        step(10);
        check(travel_warning, 1'h1);
        reverse_limit_input = 1'h0;
        step(3);
        reverse_limit_input = 1'h1;
        step(15);
        check(travel_warning, 1'h1);
        step(10);
        check({travel_warning, travel_warning_code}, 9'h0);
        $display("test torque and hold done");
        want_dir = 2'h2;
        reverse_limit_input = 1'h0;
        step(3);
        check(travel_warning, 1'h0);
        check({drive.dynamic_braking, drive.decel, motion_allow}, 4'h2);
        forward_limit_input = 1'h0;
        step(3);
        check(travel_warning, 1'h1);
        forward_limit_input = 1'h1;
        reverse_limit_input = 1'h1;
        want_dir = 2'h0;
        servo_req = 1'h0;
        step(30);
        forward_limit_input = 1'h0;
        step(3);
        check(travel_warning, 1'h0);
        servo_req = 1'h1;
        step(5);
        check(travel_warning, 1'h0);
        forward_limit_input = 1'h1;
        travel_warning_enable = 1'h0;
        step(3);
        forward_limit_input = 1'h0;
        step(3);
        check(travel_warning, 1'h0);
        travel_warning_enable = 1'h1;
        forward_limit_input = 1'h1;
        step(3);
        forward_limit_input = 1'h0;
        step(3);
        check(travel_warning, 1'h1);
        travel_warning_enable = 1'h0;
        step(2);
        check(travel_warning, 1'h0);
        $display("test warning qualifiers done");
        summarize();
    end
endmodule
